// [swr_pkg.sv]
// Purpose: shared constants and types for the supervisor watchdog reset block
// Assumes: 20 MHz ref_clk, classic Wishbone register access
// Notes:   long cycle counts are overridable from the top module
package swr_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_KHZ          = 20_000;
  localparam int unsigned RELEASE_DELAY_MS = 200;
  localparam int unsigned PRESET_A_MS      = 1600;
  localparam int unsigned PRESET_B_MS      = 10000;
  localparam logic [31:0] RELEASE_CYCLES   = 32'(RELEASE_DELAY_MS * CLK_KHZ);
  localparam logic [31:0] PRESET_A_CYCLES  = 32'(PRESET_A_MS * CLK_KHZ);
  localparam logic [31:0] PRESET_B_CYCLES  = 32'(PRESET_B_MS * CLK_KHZ);
  localparam logic [31:0] PROG_TMO_RESET   = 32'h0000_4e20;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_TMO   = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_MASK  = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;

  // ==========================================================
  // synchronised pin vector positions
  localparam int IN_W    = 6;
  localparam int IN_HOLD = 0;
  localparam int IN_SUP  = 1;
  localparam int IN_SEL  = 2;
  localparam int IN_KICK = 3;
  localparam int IN_PRG  = 4;

  // ==========================================================
  // status / mask bit positions
  localparam int EV_W       = 3;
  localparam int EV_TMO     = 0;
  localparam int EV_RST_LO  = 1;
  localparam int EV_RST_HI  = 2;

  // timeout program pin codes
  localparam logic [1:0] PRG_CAP    = 2'h0;
  localparam logic [1:0] PRG_PRE_A  = 2'h1;
  localparam logic [1:0] PRG_PRE_B  = 2'h2;
  localparam logic [1:0] PRG_OPEN   = 2'h3;

  typedef enum logic [1:0] {
    SWR_HOLD,
    SWR_RUN,
    SWR_FAULT
  } swr_state_t;
endpackage

// [swr_supervisor.sv]
// Purpose: reset supervisor with watchdog, fault pulse and Wishbone registers
// Assumes: supply comparisons arrive as digital levels on pins
// Notes:   all state lives in one struct registered by one process
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ns
// Contract
// - Reset output low whenever manual hold input is low.
// - After manual hold releases, reset stays low for the release delay.
// - Reset output low as soon as supply drops below trip level.
// - Supply back in range starts release count; reset rises at completion.
// - Reset held low until supply above trip plus hysteresis and delay elapsed.
// - Select input low disables the watchdog; no timeout ever raised.
// - Timeout chosen by program pin setting alone; select input only enables the watchdog.
// - Kick ignored while reset low, fault low, or watchdog disabled.
// - Fault output asserts when timeout expires without accepted kick edge.
// - Fault output asserts only while reset output is high.
// - Fault output held low for the release delay, then released.
// - Fault output released to high impedance whenever reset goes low.
module swr_supervisor #(
  parameter logic [31:0] RELEASE_CYC = swr_pkg::RELEASE_CYCLES,
  parameter logic [31:0] PRESET_A    = swr_pkg::PRESET_A_CYCLES,
  parameter logic [31:0] PRESET_B    = swr_pkg::PRESET_B_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        manual_hold_in_n,
  input  wire logic        supply_ok_in,
  input  wire logic        watchdog_select_in,
  input  wire logic        watchdog_kick_in,
  input  wire logic [1:0]  timeout_program_pin,
  output logic             sys_reset_out_n,
  output logic             watchdog_fault_out_n,
  output logic             watchdog_fault_oe,
  output logic             irq,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdat,
  output logic [31:0]      wb_rdat,
  output logic             wb_ack
);

  // ==========================================================
  // state record
  typedef struct packed {
    swr_pkg::swr_state_t          state;
    logic [31:0]                  dly;
    logic [31:0]                  wdc;
    logic                         rst_n;
    logic                         f_oe;
    logic                         f_out;
    logic [swr_pkg::IN_W-1:0]     s1;
    logic [swr_pkg::IN_W-1:0]     s2;
    logic [swr_pkg::IN_W-1:0]     s3;
    logic [swr_pkg::IN_W-1:0]     filt;
    logic [31:0]                  tmo_prog;
    logic [swr_pkg::EV_W-1:0]     status;
    logic [swr_pkg::EV_W-1:0]     mask;
    logic                         irq;
    logic                         ack;
    logic [31:0]                  rdat;
  } swr_regs_t;

  swr_regs_t r_r;
  swr_regs_t r_nxt;

  logic [swr_pkg::IN_W-1:0] pins;
  logic [swr_pkg::IN_W-1:0] agree;
  logic                     hold;
  logic                     wd_en;
  logic                     kick_fall;
  logic [31:0]              tmo;
  logic [32:0]              wdc_inc;
  logic [32:0]              dly_inc;
  logic                     dly_done;
  logic                     req;
  logic [swr_pkg::EV_W-1:0] ev;
  logic [swr_pkg::EV_W-1:0] w1c;

  assign pins = {timeout_program_pin, watchdog_kick_in, watchdog_select_in,
                 supply_ok_in, manual_hold_in_n};

  // a pin change counts once the second and third stages agree
  assign agree = ~(r_r.s2 ^ r_r.s3);

  // ==========================================================
  // derived conditions
  always_comb
  begin
    hold      = ~r_r.filt[swr_pkg::IN_HOLD] | ~r_r.filt[swr_pkg::IN_SUP];
    wd_en     = r_r.filt[swr_pkg::IN_SEL];
    // only a settled high-to-low change is a kick
    kick_fall = r_r.filt[swr_pkg::IN_KICK] & agree[swr_pkg::IN_KICK]
              & ~r_r.s3[swr_pkg::IN_KICK];
    // pin setting picks the source of the timeout
    unique case (r_r.filt[swr_pkg::IN_PRG +: 2])
      swr_pkg::PRG_CAP:   tmo = r_r.tmo_prog;
      swr_pkg::PRG_PRE_A: tmo = PRESET_A;
      swr_pkg::PRG_PRE_B: tmo = PRESET_B;
      swr_pkg::PRG_OPEN:  tmo = PRESET_B;
    endcase
    wdc_inc  = {1'b0, r_r.wdc} + 33'h0_0000_0001;
    dly_inc  = {1'b0, r_r.dly} + 33'h0_0000_0001;
    dly_done = dly_inc >= {1'b0, RELEASE_CYC};
    req      = wb_cyc & wb_stb & ~r_r.ack;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    r_nxt      = r_r;
    r_nxt.s1   = pins;
    r_nxt.s2   = r_r.s1;
    r_nxt.s3   = r_r.s2;
    r_nxt.filt = (agree & r_r.s3) | (~agree & r_r.filt);
    r_nxt.f_out = 1'b0;
    ev         = '0;
    w1c        = '0;

    // supervisor and watchdog sequence
    if (hold)
    begin
      // hold restarts the release count on every cycle
      r_nxt.state = swr_pkg::SWR_HOLD;
      r_nxt.dly   = '0;
      r_nxt.wdc   = '0;
      r_nxt.rst_n = 1'b0;
      r_nxt.f_oe  = 1'b0;
      ev[swr_pkg::EV_RST_LO] = r_r.rst_n;
    end
    else
    begin
      unique case (r_r.state)
        swr_pkg::SWR_HOLD:
        begin
          if (dly_done)
          begin
            r_nxt.state = swr_pkg::SWR_RUN;
            r_nxt.rst_n = 1'b1;
            r_nxt.dly   = '0;
            r_nxt.wdc   = '0;
            ev[swr_pkg::EV_RST_HI] = 1'b1;
          end
          else
          begin
            r_nxt.dly = dly_inc[31:0];
          end
        end
        swr_pkg::SWR_RUN:
        begin
          if (!wd_en)
          begin
            r_nxt.wdc = '0;
          end
          else if (kick_fall)
          begin
            r_nxt.wdc = '0;
          end
          else if (wdc_inc >= {1'b0, tmo})
          begin
            // reset is high here, so the fault may start
            r_nxt.state = swr_pkg::SWR_FAULT;
            r_nxt.f_oe  = 1'b1;
            r_nxt.wdc   = '0;
            r_nxt.dly   = '0;
            ev[swr_pkg::EV_TMO] = 1'b1;
          end
          else
          begin
            r_nxt.wdc = wdc_inc[31:0];
          end
        end
        swr_pkg::SWR_FAULT:
        begin
          // kicks have no effect while the fault is driven
          if (dly_done)
          begin
            r_nxt.state = swr_pkg::SWR_RUN;
            r_nxt.f_oe  = 1'b0;
            r_nxt.dly   = '0;
            r_nxt.wdc   = '0;
          end
          else
          begin
            r_nxt.dly = dly_inc[31:0];
          end
        end
        default:
        begin
          r_nxt.state = swr_pkg::SWR_HOLD;
        end
      endcase
    end

    // register writes, byte lanes honoured on the timeout word
    r_nxt.ack  = req;
    r_nxt.rdat = '0;
    if (req && wb_we)
    begin
      unique case (wb_adr)
        swr_pkg::ADDR_TMO:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel[b])
            begin
              r_nxt.tmo_prog[8*b +: 8] = wb_wdat[8*b +: 8];
            end
          end
        end
        swr_pkg::ADDR_STAT:
        begin
          w1c = wb_sel[0] ? wb_wdat[swr_pkg::EV_W-1:0] : '0;
        end
        swr_pkg::ADDR_MASK:
        begin
          if (wb_sel[0])
          begin
            r_nxt.mask = wb_wdat[swr_pkg::EV_W-1:0];
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (req)
    begin
      // unmapped reads return zero but are still acknowledged
      unique case (wb_adr)
        swr_pkg::ADDR_TMO:   r_nxt.rdat = r_r.tmo_prog;
        swr_pkg::ADDR_STAT:  r_nxt.rdat = 32'(r_r.status);
        swr_pkg::ADDR_MASK:  r_nxt.rdat = 32'(r_r.mask);
        swr_pkg::ADDR_STATE: r_nxt.rdat = {22'h0, r_r.filt, r_r.f_oe,
                                           r_r.rst_n, r_r.state};
        default:             r_nxt.rdat = '0;
      endcase
    end

    // set beats clear so no event is lost
    r_nxt.status = (r_r.status & ~w1c) | ev;
    r_nxt.irq    = |(r_nxt.status & r_nxt.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r_r          <= '0;
      r_r.state    <= swr_pkg::SWR_HOLD;
      r_r.tmo_prog <= swr_pkg::PROG_TMO_RESET;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign sys_reset_out_n      = r_r.rst_n;
  assign watchdog_fault_out_n = r_r.f_out;
  assign watchdog_fault_oe    = r_r.f_oe;
  assign irq                  = r_r.irq;
  assign wb_rdat              = r_r.rdat;
  assign wb_ack               = r_r.ack;

  // ==========================================================
  // checks
  // properties watch filtered pins, so pin latency stays outside them
  sequence s_hold_seen;
    hold;
  endsequence

  sequence s_run_expire;
    r_r.state == swr_pkg::SWR_RUN && wd_en && !kick_fall && wdc_inc >= {1'b0, tmo};
  endsequence

  a_manual_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !r_r.filt[swr_pkg::IN_HOLD] |=> !sys_reset_out_n)
    else $error("reset not low under manual hold");

  a_uv_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !r_r.filt[swr_pkg::IN_SUP] |=> !sys_reset_out_n)
    else $error("reset not low under undervoltage");

  a_release_delay: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(sys_reset_out_n) |-> $past(r_r.dly) + 32'h1 == RELEASE_CYC && !$past(hold))
    else $error("reset released before delay");

  a_hold_restart: assert property (@(posedge ref_clk) disable iff (rst)
    s_hold_seen |=> r_r.dly == 32'h0 && r_r.state == swr_pkg::SWR_HOLD)
    else $error("release count not restarted by hold");

  a_wd_off: assert property (@(posedge ref_clk) disable iff (rst)
    !wd_en && !watchdog_fault_oe |=> !watchdog_fault_oe)
    else $error("fault raised with watchdog disabled");

  a_tmo_fire: assert property (@(posedge ref_clk) disable iff (rst)
    s_run_expire and !hold |=> watchdog_fault_oe && r_r.status[swr_pkg::EV_TMO])
    else $error("timeout did not raise fault");

  a_fault_in_run: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_fault_oe |-> sys_reset_out_n && !watchdog_fault_out_n)
    else $error("fault driven during reset");

  a_fault_width: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(watchdog_fault_oe) && sys_reset_out_n |-> $past(r_r.dly) + 32'h1 == RELEASE_CYC)
    else $error("fault pulse width wrong");

  a_fault_release: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(sys_reset_out_n) |-> !watchdog_fault_oe)
    else $error("fault still driven as reset falls");

  a_kick_restart: assert property (@(posedge ref_clk) disable iff (rst)
    kick_fall && wd_en && !hold && r_r.state == swr_pkg::SWR_RUN |=> r_r.wdc == 32'h0)
    else $error("kick did not restart count");

  a_kick_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    r_r.state != swr_pkg::SWR_RUN |-> r_r.wdc == 32'h0)
    else $error("timeout count moved outside run");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(r_r.status[swr_pkg::EV_TMO]) && r_r.mask[swr_pkg::EV_TMO] |-> irq)
    else $error("unmasked event did not raise irq");

  // a late kick must not shorten the fault pulse
  a_fault_kick: assert property (@(posedge ref_clk) disable iff (rst)
    r_r.state == swr_pkg::SWR_FAULT && !hold && !dly_done |=> watchdog_fault_oe)
    else $error("fault pulse cut short");

  a_sel_off_count: assert property (@(posedge ref_clk) disable iff (rst)
    r_r.state == swr_pkg::SWR_RUN && !wd_en |=> r_r.wdc == 32'h0)
    else $error("timeout count moved with watchdog disabled");

  a_ack_single: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack |=> !wb_ack)
    else $error("bus acknowledge longer than one cycle");

  a_rdat_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !wb_ack |-> wb_rdat == 32'h0)
    else $error("read data not zero outside acknowledge");

endmodule

// [swr_mcu_model.sv]
// Purpose: processor model that kicks the supervisor's watchdog
// Assumes: kick low pulse of 4 cycles, long enough for the pin filter
// Notes:   kick is always driven high or low, never left floating
`timescale 1ns/1ns
module swr_mcu_model (
  input  wire logic       ref_clk,
  input  wire logic       kick_en,
  input  wire logic [7:0] period,
  output logic            kick = 1'b1
);
  logic [7:0] cnt_r = 8'h00;

  // ==========================================================
  // kick generator
  // one falling edge per period of 4 or more; stays high when told to stop
  always_ff @(posedge ref_clk)
  begin
    if (!kick_en || cnt_r >= period)
    begin
      cnt_r <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
    end
    kick <= !(kick_en && cnt_r < 8'h04);
  end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the supervisor watchdog block
// Assumes: short release and preset counts set by parameter
// Notes:   pin filter adds 3-4 cycles, so pin timings use a small window
`timescale 1ns/1ns
module tb;
  localparam int REL = 20;
  localparam int PA  = 100;
  localparam int PB  = 200;
  logic        ref_clk, rst, manual_hold_in_n, supply_ok_in, watchdog_select_in;
  logic        watchdog_kick_in, watchdog_fault_out_n, watchdog_fault_oe, irq;
  logic        sys_reset_out_n, kick_en, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [1:0]  timeout_program_pin;
  logic [7:0]  wb_adr, kick_period;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd, tmo;
  int          n_mismatch, checks, n, bad, t;
  integer      seed;
  // open-drain fault wire with its pull-up
  wire         fault_pin = watchdog_fault_oe ? watchdog_fault_out_n : 1'b1;

  swr_supervisor #(.RELEASE_CYC(32'(REL)), .PRESET_A(32'(PA)), .PRESET_B(32'(PB)))
    swr_supervisor_inst (.ref_clk, .rst, .manual_hold_in_n, .supply_ok_in,
    .watchdog_select_in, .watchdog_kick_in, .timeout_program_pin, .sys_reset_out_n,
    .watchdog_fault_out_n, .watchdog_fault_oe, .irq, .wb_cyc, .wb_stb, .wb_we,
    .wb_adr, .wb_sel, .wb_wdat, .wb_rdat, .wb_ack);
  swr_mcu_model swr_mcu_model_inst (.ref_clk, .kick_en, .period(kick_period),
    .kick(watchdog_kick_in));

  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic win(input string nm, input int v, input int lo, input int hi);
    chk(nm, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // preset codes 2 and 3 share the long preset
  function automatic int tmo_exp(input int p, input logic [31:0] r);
    return p == 0 ? int'(r) : p == 1 ? PA : PB;
  endfunction

  // sampled pre-edge, so counts are in whole cycles
  task automatic wait_for(input int s, input logic lvl, output int c);
    c = 0;
    while ((s == 0 ? sys_reset_out_n : watchdog_fault_oe) !== lvl)
    begin
      @(posedge ref_clk);
      c++;
      if (c > 2000)
      begin
        chk("wait", 32'h0, 32'h1);
        end_sim();
      end
    end
  endtask

  task automatic no_fault(input int c, output int b);
    b = 0;
    repeat (c)
    begin
      @(posedge ref_clk);
      b |= int'(watchdog_fault_oe !== 1'b0);
    end
  endtask

  // ==========================================================
  // wishbone classic single cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (wb_ack !== 1'b1 && i < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("wb_ack", 32'(wb_ack), 32'h1);
    if (wb_ack !== 1'b1)
      end_sim();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 46445;
    {n_mismatch, checks} = '0;
    {rst, manual_hold_in_n, supply_ok_in} = 3'h7;
    {watchdog_select_in, kick_en, timeout_program_pin} = '0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hf;
    kick_period = 8'h14;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, swr_pkg::ADDR_TMO, 32'h0);
    chk("tmo_rst", rd, swr_pkg::PROG_TMO_RESET);
    wb(1'b0, swr_pkg::ADDR_MASK, 32'h0);
    chk("mask_rst", rd, 32'h0);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    wait_for(0, 1'b1, n);
    // hold by the manual pin, then by undervoltage
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        manual_hold_in_n <= 1'b0;
      else
        supply_ok_in <= 1'b0;
      wait_for(0, 1'b0, n);
      win("hold_lat", n, 0, 6);
      repeat (30) @(posedge ref_clk);
      chk("hold_lvl", 32'(sys_reset_out_n), 32'h0);
      manual_hold_in_n <= 1'b1;
      supply_ok_in <= 1'b1;
      wait_for(0, 1'b1, n);
      win("rel_delay", n, REL, REL + 6);
    end
    // every program pin code; programmed count drawn at random
    watchdog_select_in <= 1'b1;
    manual_hold_in_n <= 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      tmo = 32'h28 + 32'($random(seed) & 31);
      t = tmo_exp(p, tmo);
      wb(1'b1, swr_pkg::ADDR_TMO, tmo);
      wb(1'b1, swr_pkg::ADDR_MASK, {31'h0, p != 3});
      timeout_program_pin <= 2'(p);
      repeat (8) @(posedge ref_clk);
      manual_hold_in_n <= 1'b1;
      wait_for(0, 1'b1, n);
      wait_for(1, 1'b1, n);
      win("first_tmo", n, t - 3, t + 6);
      chk("fault_pin", 32'(fault_pin), 32'h0);
      chk("rst_in_fault", 32'(sys_reset_out_n), 32'h1);
      wait_for(1, 1'b0, n);
      win("fault_len", n, REL - 1, REL + 1);
      chk("irq", 32'(irq), 32'(p != 3));
      wait_for(1, 1'b1, n);
      win("next_tmo", n, t - 3, t + 6);
      manual_hold_in_n <= 1'b0;
      wait_for(1, 1'b0, n);
      win("fault_drop", n, 0, 6);
      chk("drop_rst", 32'(sys_reset_out_n), 32'h0);
      chk("drop_pin", 32'(fault_pin), 32'h1);
      wb(1'b0, swr_pkg::ADDR_STAT, 32'h0);
      chk("stat_set", 32'(rd[2:0]), 32'h7);
      wb(1'b1, swr_pkg::ADDR_STAT, 32'h7);
      wb(1'b0, swr_pkg::ADDR_STAT, 32'h0);
      chk("stat_clr", 32'(rd[2:0]), 32'h0);
      chk("irq_clr", 32'(irq), 32'h0);
    end
    // kicks at a random pace keep the watchdog quiet
    manual_hold_in_n <= 1'b1;
    timeout_program_pin <= 2'h0;
    wb(1'b1, swr_pkg::ADDR_TMO, 32'h3c);
    kick_period <= 8'h0a + 8'($random(seed) & 31);
    kick_en <= 1'b1;
    wait_for(0, 1'b1, n);
    no_fault(400, bad);
    chk("kick_keeps", 32'(bad), 32'h0);
    wb(1'b0, swr_pkg::ADDR_STATE, 32'h0);
    chk("state", 32'(rd[2:0]), 32'({1'b1, swr_pkg::SWR_RUN}));
    watchdog_select_in <= 1'b0;
    kick_en <= 1'b0;
    no_fault(400, bad);
    chk("disabled", 32'(bad), 32'h0);
    watchdog_select_in <= 1'b1;
    wait_for(1, 1'b1, n);
    win("enable_tmo", n, 57, 68);
    kick_period <= 8'h08;
    kick_en <= 1'b1;
    wait_for(1, 1'b0, n);
    win("kick_in_fault", n, REL - 1, REL + 1);
    // mid-run reset drops every output and returns the programmed timeout to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("rst_outs", 32'({sys_reset_out_n, watchdog_fault_oe, irq}), 32'h0);
    rst <= 1'b0;
    wb(1'b0, swr_pkg::ADDR_TMO, 32'h0);
    chk("tmo_rst2", rd, swr_pkg::PROG_TMO_RESET);
    end_sim();
  end
endmodule
